// ---- clkdiv_pkg.sv ----
package clkdiv_pkg;

  // divide ratio select encoding
  localparam logic [1:0] DIV_SEL_2 = 2'h0;
  localparam logic [1:0] DIV_SEL_4 = 2'h1;
  localparam logic [1:0] DIV_SEL_8 = 2'h2;

  // input source select encoding
  localparam logic [1:0] SRC_LOOP    = 2'h0;
  localparam logic [1:0] SRC_SLAVE   = 2'h1;
  localparam logic [1:0] SRC_ROUTING = 2'h2;
  localparam logic [1:0] SRC_PIN     = 2'h3;

  // counter width serves up to divide by eight
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;

  // edges from release to first divided rising edge
  localparam int START_EDGES = 1;

  typedef enum logic [1:0]
  {
    ST_HELD    = 2'b00,
    ST_WAIT    = 2'b01,
    ST_RUNNING = 2'b11
  } div_state_e;

  typedef struct packed
  {
    logic loop_clk;
    logic slave_clk;
    logic routing_clk;
    logic pin_clk;
  } clk_sources_s;

endpackage

// ---- clk_source_sync.sv ----
`timescale 1ns/1ns
module clk_source_sync
#(
  parameter int STAGES = 2
)
(
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic [STAGES-1:0] sync_r;

  initial
  begin
    if (STAGES < 2)
      $error("clk_source_sync needs at least two stages");
  end

  // first stage is read only by the second stage
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sync_r <= '0;
    else
      sync_r <= {sync_r[STAGES-2:0], async_in};
  end

  assign sync_out = sync_r[STAGES-1];

endmodule

// ---- edge_clock_divider.sv ----
`timescale 1ns/1ns
// Behaviour
// - output is selected input divided by two, four or eight.
// - output phase relative to input fixed by moment of release.
// - reset clears state and forces outputs low without a clock edge.
// - outputs resume only after release, aligned to an input edge.
// - input chosen from loop, slave delay, routing or pin sources.
// - divided outputs usable as primary clock network sources.
module edge_clock_divider
(
  input  wire logic                    clock_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    release_in,
  input  wire logic [1:0]              src_sel_in,
  input  wire logic [1:0]              div_sel_in,
  input  wire clkdiv_pkg::clk_sources_s sources_in,
  output logic                         div_clk_out,
  output logic                         primary_clk_out,
  output logic                         running_out
);

  localparam int                  W          = clkdiv_pkg::CNT_W;
  localparam logic [W-1:0]        START_LAST =
    W'(clkdiv_pkg::START_EDGES - 1);
  localparam int                  N_PINS     = 8;

  logic                           release_s;
  logic                           src_edge_s;
  logic                           src_s;
  logic                           src_d_r;
  logic                           edge_en;
  logic                           start_hit;
  logic [W-1:0]                   cnt_r;
  logic [W-1:0]                   half_mask;
  logic [W-1:0]                   start_cnt_r;
  logic [1:0]                     div_sel_r;
  logic [1:0]                     div_sel_s;
  logic [1:0]                     src_sel_s;
  logic [3:0]                     src_sync;
  logic [N_PINS-1:0]              pins_raw;
  logic [N_PINS-1:0]              pins_sync;
  logic                           div_clk_r;
  clkdiv_pkg::div_state_e         state_r;

  // the start counter must be able to reach the last start edge
  initial
  begin
    if (clkdiv_pkg::START_EDGES < 1 ||
        clkdiv_pkg::START_EDGES >= (1 << W))
      $error("start edge count does not fit the counter");
  end

  // every pin input, sources and selects alike, crosses two flops
  assign pins_raw = {sources_in, src_sel_in, div_sel_in};

  generate
    for (genvar i = 0; i < N_PINS; i++)
    begin : g_pin_sync
      clk_source_sync u_sync
      (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .async_in (pins_raw[i]),
        .sync_out (pins_sync[i])
      );
    end
  endgenerate

  // bit 7 loop, 6 slave, 5 routing, 4 pin clock
  assign src_sync  = pins_sync[7:4];
  assign src_sel_s = pins_sync[3:2];
  assign div_sel_s = pins_sync[1:0];

  // mux after the synchronisers; a select change while running
  // may show as one false edge, so selects are meant to stay put
  always_comb
  begin
    case (src_sel_s)
      clkdiv_pkg::SRC_LOOP:    src_s = src_sync[3];
      clkdiv_pkg::SRC_SLAVE:   src_s = src_sync[2];
      clkdiv_pkg::SRC_ROUTING: src_s = src_sync[1];
      default:                 src_s = src_sync[0];
    endcase
  end

  clk_source_sync u_rel_sync
  (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .async_in (release_in),
    .sync_out (release_s)
  );

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      src_d_r <= 1'b0;
    else
      src_d_r <= src_s;
  end

  // one-cycle enable per rising edge of the selected input clock
  assign src_edge_s = src_s & ~src_d_r;
  assign edge_en    = src_edge_s;

  // edges seen while waiting; fixes the distance release to first rise
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      start_cnt_r <= clkdiv_pkg::CNT_RESET;
    else if (state_r != clkdiv_pkg::ST_WAIT)
      start_cnt_r <= clkdiv_pkg::CNT_RESET;
    else if (edge_en)
      start_cnt_r <= start_cnt_r + W'(1);
  end

  assign start_hit = edge_en && (start_cnt_r == START_LAST);

  // ratio latched only while held so a change never glitches the output
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      div_sel_r <= clkdiv_pkg::DIV_SEL_2;
    else if (state_r == clkdiv_pkg::ST_HELD)
      div_sel_r <= div_sel_s;
  end

  always_comb
  begin
    case (div_sel_r)
      clkdiv_pkg::DIV_SEL_2: half_mask = 3'h0;
      clkdiv_pkg::DIV_SEL_4: half_mask = 3'h1;
      clkdiv_pkg::DIV_SEL_8: half_mask = 3'h3;
      default:               half_mask = 3'h0;
    endcase
  end

  // state leaves wait only on an input edge, so release aligns to one
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      state_r <= clkdiv_pkg::ST_HELD;
    else
    begin
      case (state_r)
        clkdiv_pkg::ST_HELD:
          if (release_s)
            state_r <= clkdiv_pkg::ST_WAIT;
        clkdiv_pkg::ST_WAIT:
          if (start_hit)
            state_r <= clkdiv_pkg::ST_RUNNING;
        clkdiv_pkg::ST_RUNNING:
          state_r <= clkdiv_pkg::ST_RUNNING;
        default:
          state_r <= clkdiv_pkg::ST_HELD;
      endcase
    end
  end

  // counter restarts from zero at the first rise, fixing the phase
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cnt_r <= clkdiv_pkg::CNT_RESET;
    else if (state_r != clkdiv_pkg::ST_RUNNING)
      cnt_r <= clkdiv_pkg::CNT_RESET;
    else if (edge_en)
    begin
      if ((cnt_r & ~half_mask) != 3'h0 || cnt_r == half_mask)
        cnt_r <= clkdiv_pkg::CNT_RESET;
      else
        cnt_r <= cnt_r + W'(1);
    end
  end

  // first rise on the first input edge after release; toggles each half
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      div_clk_r <= 1'b0;
    else if (state_r == clkdiv_pkg::ST_HELD)
      div_clk_r <= 1'b0;
    else if (state_r == clkdiv_pkg::ST_WAIT && start_hit)
      div_clk_r <= 1'b1;
    else if (state_r == clkdiv_pkg::ST_RUNNING && edge_en
             && cnt_r == half_mask)
      div_clk_r <= ~div_clk_r;
  end

  assign div_clk_out     = div_clk_r;
  // same registered clock handed to the global network
  assign primary_clk_out = div_clk_r;
  assign running_out     = (state_r == clkdiv_pkg::ST_RUNNING);

endmodule

// ---- src_clock_model.sv ----
`timescale 1ns/1ns
module src_clock_model
(
  output clkdiv_pkg::clk_sources_s srcs_out
);
  // free running, edges on multiples of 50 ns to stay off rising clock
  initial srcs_out = '0;
  always #150 srcs_out.loop_clk = ~srcs_out.loop_clk;
  always #200 srcs_out.slave_clk = ~srcs_out.slave_clk;
  always #250 srcs_out.routing_clk = ~srcs_out.routing_clk;
  always #350 srcs_out.pin_clk = ~srcs_out.pin_clk;
endmodule

// ---- edge_clock_divider_sva.sv ----
`timescale 1ns/1ns
module edge_clock_divider_sva
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic release_in,
  input wire logic div_clk_out,
  input wire logic primary_clk_out,
  input wire logic running_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_same_feed: assert property (primary_clk_out == div_clk_out)
    else $error("feed differs");
  a_idle_low: assert property (!running_out |-> !div_clk_out)
    else $error("idle high");
  a_run_late: assert property ($rose(running_out) |-> $past(release_in, 3))
    else $error("early run");
  a_first_rise: assert property ($rose(running_out) |-> div_clk_out)
    else $error("no first rise");
  a_run_holds: assert property (running_out |=> running_out)
    else $error("run dropped");
  a_phase_hold: assert property ($changed(div_clk_out) |=> $stable(div_clk_out)[*2])
    else $error("short phase");
  a_reset_clear: assert property ($rose(rst_b_in) |-> !running_out && !div_clk_out)
    else $error("not cleared");
  c_run: cover property ($rose(running_out));
  c_tog: cover property ($fell(div_clk_out));
  c_rst: cover property ($rose(rst_b_in));
endmodule

// ---- edge_clock_divider_tb_top.sv ----
`timescale 1ns/1ns
module edge_clock_divider_tb_top;
  logic                     clock_in, rst_b_in, release_in;
  logic [1:0]               src_sel_in, div_sel_in;
  clkdiv_pkg::clk_sources_s srcs;
  logic                     div_clk_out, primary_clk_out, running_out;
  int                       fail_count = 0, n_checks = 0;
  int                       half_t [4] = '{3, 4, 5, 7};
  src_clock_model src (.srcs_out(srcs));
  edge_clock_divider uut (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .release_in(release_in), .src_sel_in(src_sel_in),
    .div_sel_in(div_sel_in), .sources_in(srcs), .div_clk_out(div_clk_out),
    .primary_clk_out(primary_clk_out), .running_out(running_out));
  initial
  begin
    clock_in = 0;
    forever #25 clock_in = ~clock_in;
  end
  task check(string w, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s exp %h got %h", w, e, g);
    end
  endtask
  task complete_run;
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wait_lvl(logic v, inout int n);
    while (div_clk_out !== v && n < 400)
    begin
      @(negedge clock_in);
      n++;
    end
  endtask
  task rise_gap(output int n);
    n = 0;
    wait_lvl(0, n);
    wait_lvl(1, n);
    n = 0;
    wait_lvl(0, n);
    wait_lvl(1, n);
  endtask
  task start(logic [1:0] s, logic [1:0] d);
    int k;
    @(negedge clock_in);
    {rst_b_in, release_in, src_sel_in, div_sel_in} = {2'b00, s, d};
    repeat (3) @(negedge clock_in);
    rst_b_in = 1;
    repeat (6) @(negedge clock_in);
    check("idle", 8'h00, {running_out, div_clk_out});
    release_in = 1;
    for (k = 0; k < 200 && running_out !== 1'b1; k++) @(negedge clock_in);
    check("running", 8'h01, running_out);
  endtask
  task ratio_case(logic [1:0] s, logic [1:0] d);
    int n;
    int p;
    p = (2 << d) * 2 * half_t[s];
    start(s, d);
    rise_gap(n);
    check("period", p, n);
    div_sel_in = d ^ 2'h1;
    rise_gap(n);
    check("locked period", p, n);
  endtask
  task reset_case;
    int n;
    n = 0;
    start(2'h0, 2'h0);
    wait_lvl(1, n);
    @(negedge clock_in);
    rst_b_in = 0;
    #1 check("reset out", 8'h00, {running_out, div_clk_out});
    start(2'h3, 2'h1);
    rise_gap(n);
    check("restart period", 8'h38, n);
  endtask
  initial
  begin
    {rst_b_in, release_in, src_sel_in, div_sel_in} = '0;
    for (int s = 0; s < 4; s++)
      for (int d = 0; d < 3; d++) ratio_case(s[1:0], d[1:0]);
    reset_case();
    complete_run();
  end
  initial
  begin
    #2000000;
    fail_count++;
    complete_run();
  end
endmodule
bind edge_clock_divider edge_clock_divider_sva chk (.clock_in(clock_in),
  .rst_b_in(rst_b_in), .release_in(release_in), .div_clk_out(div_clk_out),
  .primary_clk_out(primary_clk_out), .running_out(running_out));
